/* File: hw/sdc_consts.vh */
// timing constants and settings encodings for the stepper drive control block
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
// ****************************************
// timing
// ****************************************
`define SDC_CLK_MHZ        100
`define SDC_PWM_HZ         22000
`define SDC_PWM_CYC        (`SDC_CLK_MHZ * 1000000 / `SDC_PWM_HZ)
`define SDC_IDLE_MS        1000
`define SDC_IDLE_CYC       (`SDC_IDLE_MS * `SDC_CLK_MHZ * 1000)
`define SDC_INIT_US        100
`define SDC_INIT_CYC       (`SDC_INIT_US * `SDC_CLK_MHZ)
`define SDC_FLASH_MS       50
`define SDC_FLASH_CYC      (`SDC_FLASH_MS * `SDC_CLK_MHZ * 1000)
// ****************************************
// settings encodings
// ****************************************
`define SDC_CUR_MIN        6'd9
`define SDC_CUR_MAX        6'd40
`define SDC_IDLE_NONE      2'h0
`define SDC_IDLE_HALF      2'h1
`define SDC_IDLE_ZERO      2'h2
`define SDC_MODE_STEPDIR   1'b0
`define SDC_MODE_CWCCW     1'b1
`define SDC_RES_FULL       1'b0
`define SDC_RES_HALF       1'b1
`define SDC_PHASE_W        3
`define SDC_PHASE_RST      3'h0
`endif

/* File: hw/sdc_drive.v */
// stepper drive control: pulse decode, current, faults, led
`timescale 1ns/1ps
`default_nettype none
`include "sdc_consts.vh"
module sdc_drive #(
  parameter integer IDLE_CYC  = `SDC_IDLE_CYC,
  parameter integer INIT_CYC  = `SDC_INIT_CYC,
  parameter integer FLASH_CYC = `SDC_FLASH_CYC,
  parameter integer PWM_CYC   = `SDC_PWM_CYC
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       pulse_a_input,
  input  wire       pulse_b_input,
  input  wire       disable_in,
  input  wire       short_phase_in,
  input  wire       short_ground_in,
  input  wire       over_temp_in,
  input  wire       pulse_mode_switch,
  input  wire       resolution_switch,
  input  wire [5:0] current_switch,
  input  wire [1:0] idle_switch,
  output reg        fault_out,
  output reg        led_green,
  output reg        led_red,
  output reg        step_out,
  output reg        dir_out,
  output reg  [2:0] phase_out,
  output reg  [5:0] current_set,
  output reg        pwm_a,
  output reg        pwm_b,
  output reg        bridge_en,
  output reg        ready
);
  // ****************************************
  // input synchronisers
  // ****************************************
  wire a_s;
  wire b_s;
  wire dis_s;
  wire sp_s;
  wire sg_s;
  wire ot_s;
  sdc_sync u_a  (.clk(clk), .rst(rst), .din(pulse_a_input),   .dout(a_s));
  sdc_sync u_b  (.clk(clk), .rst(rst), .din(pulse_b_input),   .dout(b_s));
  sdc_sync u_d  (.clk(clk), .rst(rst), .din(disable_in),      .dout(dis_s));
  sdc_sync u_sp (.clk(clk), .rst(rst), .din(short_phase_in),  .dout(sp_s));
  sdc_sync u_sg (.clk(clk), .rst(rst), .din(short_ground_in), .dout(sg_s));
  sdc_sync u_ot (.clk(clk), .rst(rst), .din(over_temp_in),    .dout(ot_s));

  // ****************************************
  // initialization and idle setting capture
  // ****************************************
  reg [31:0] init_cnt_r;
  reg [1:0]  idle_sel_r;
  always @(posedge clk) begin
    if (rst) begin
      init_cnt_r <= 32'h0;
      ready      <= 1'b0;
      idle_sel_r <= `SDC_IDLE_NONE;
    end else if (!ready) begin
      // setting sampled every cycle until ready so later switch moves need a reset
      idle_sel_r <= (idle_switch == 2'h3) ? `SDC_IDLE_ZERO : idle_switch;
      if (init_cnt_r >= INIT_CYC - 1) begin
        ready <= 1'b1;
      end else begin
        init_cnt_r <= init_cnt_r + 32'h1;
      end
    end
  end

  // ****************************************
  // fault latch
  // ****************************************
  reg fault_r;
  wire fault_now = sp_s | sg_s | ot_s;
  always @(posedge clk) begin
    if (rst) begin
      fault_r <= 1'b0;
    end else if (fault_now) begin
      fault_r <= 1'b1;
    end else if (dis_s) begin
      fault_r <= 1'b0;
    end
  end
  wire run = ready & ~fault_r & ~dis_s;

  // ****************************************
  // pulse decode
  // ****************************************
  reg a_d_r;
  reg b_d_r;
  always @(posedge clk) begin
    if (rst) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
    end else begin
      a_d_r <= a_s;
      b_d_r <= b_s;
    end
  end
  wire a_rise = a_s & ~a_d_r;
  wire b_rise = b_s & ~b_d_r;
  reg step_nxt;
  reg dir_nxt;
  always @* begin
    if (pulse_mode_switch == `SDC_MODE_CWCCW) begin
      step_nxt = a_rise ^ b_rise;
      dir_nxt  = a_rise;
    end else begin
      step_nxt = a_rise;
      dir_nxt  = b_s;
    end
  end
  wire step_ok = step_nxt & run;

  // ****************************************
  // step sequencer
  // ****************************************
  always @(posedge clk) begin
    if (rst) begin
      step_out  <= 1'b0;
      dir_out   <= 1'b0;
      phase_out <= `SDC_PHASE_RST;
    end else begin
      step_out <= step_ok;
      if (step_ok) begin
        dir_out <= dir_nxt;
        // full step moves bits 2:1 by one and clears bit 0, two half-step phases on from an even one; 8 phases per electrical cycle
        if (resolution_switch == `SDC_RES_HALF) begin
          phase_out <= dir_nxt ? phase_out + 3'h1 : phase_out - 3'h1;
        end else begin
          phase_out <= dir_nxt ? {phase_out[2:1] + 2'h1, 1'b0}
                               : {phase_out[2:1] - 2'h1, 1'b0};
        end
      end
    end
  end

  // ****************************************
  // idle reduction and current setpoint
  // ****************************************
  reg [31:0] idle_cnt_r;
  reg        idle_r;
  always @(posedge clk) begin
    if (rst) begin
      idle_cnt_r <= 32'h0;
      idle_r     <= 1'b0;
    end else if (step_ok) begin
      idle_cnt_r <= 32'h0;
      idle_r     <= 1'b0;
    end else if (idle_cnt_r >= IDLE_CYC - 1) begin
      idle_r <= 1'b1;
    end else begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end
  reg [5:0] cur_nxt;
  reg [5:0] cur_clip;
  always @* begin
    if (current_switch < `SDC_CUR_MIN) begin
      cur_clip = `SDC_CUR_MIN;
    end else if (current_switch > `SDC_CUR_MAX) begin
      cur_clip = `SDC_CUR_MAX;
    end else begin
      cur_clip = current_switch;
    end
    if (!ready || fault_r || dis_s) begin
      cur_nxt = 6'h0;
    // the accepted step itself lifts the reduction, so the setpoint is full with step_out
    end else if (idle_r && !step_ok && idle_sel_r == `SDC_IDLE_HALF) begin
      cur_nxt = {1'b0, cur_clip[5:1]};
    end else if (idle_r && !step_ok && idle_sel_r == `SDC_IDLE_ZERO) begin
      cur_nxt = 6'h0;
    end else begin
      cur_nxt = cur_clip;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      current_set <= 6'h0;
      bridge_en   <= 1'b0;
    end else begin
      current_set <= cur_nxt;
      bridge_en   <= (cur_nxt != 6'h0);
    end
  end

  // ****************************************
  // pwm carrier
  // ****************************************
  reg [15:0] pwm_cnt_r;
  // product needs 32 bits: period times full setpoint overflows 16
  wire [31:0] duty_full = (PWM_CYC * {26'h0, current_set}) / 32'd40;
  wire [15:0] duty      = duty_full[15:0];
  always @(posedge clk) begin
    if (rst) begin
      pwm_cnt_r <= 16'h0;
      pwm_a     <= 1'b0;
      pwm_b     <= 1'b0;
    end else begin
      pwm_cnt_r <= (pwm_cnt_r >= PWM_CYC - 1) ? 16'h0 : pwm_cnt_r + 16'h1;
      // phase bits 2 and 1 pick which windings are driven; both off at zero duty
      pwm_a <= bridge_en & (pwm_cnt_r < duty) & ~phase_out[2];
      pwm_b <= bridge_en & (pwm_cnt_r < duty) & (phase_out[2] | phase_out[1]);
    end
  end

  // ****************************************
  // fault output and led
  // ****************************************
  reg [31:0] flash_cnt_r;
  reg        flash_r;
  reg        active_r;
  always @(posedge clk) begin
    if (rst) begin
      flash_cnt_r <= 32'h0;
      flash_r     <= 1'b0;
      active_r    <= 1'b0;
      fault_out   <= 1'b0;
      led_green   <= 1'b0;
      led_red     <= 1'b0;
    end else begin
      if (step_ok) begin
        active_r <= 1'b1;
      end else if (idle_r) begin
        active_r <= 1'b0;
      end
      if (flash_cnt_r >= FLASH_CYC - 1) begin
        flash_cnt_r <= 32'h0;
        flash_r     <= ~flash_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 32'h1;
      end
      fault_out <= ready & ~fault_r & ~fault_now;
      led_red   <= fault_r | fault_now;
      led_green <= ready & ~fault_r & ~fault_now & (~active_r | flash_r);
    end
  end
endmodule // sdc_drive
`default_nettype wire

/* File: hw/sdc_sync.v */
// three-flop input synchroniser with agreement check
`timescale 1ns/1ps
`default_nettype none
module sdc_sync (
  input  wire clk,
  input  wire rst,
  input  wire din,
  output reg  dout
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // s1 only feeds s2; a change counts once s2 and s3 agree
  always @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // sdc_sync
`default_nettype wire

/* File: tb/sdc_drive_checker.sv */
// port checker of the stepper drive control block
`timescale 1ns/1ps
`default_nettype none
module sdc_drive_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       disable_in,
  input wire logic       short_phase_in,
  input wire logic       short_ground_in,
  input wire logic       over_temp_in,
  input wire logic       resolution_switch,
  input wire logic [5:0] current_switch,
  input wire logic       fault_out,
  input wire logic       led_green,
  input wire logic       led_red,
  input wire logic       step_out,
  input wire logic [2:0] phase_out,
  input wire logic [5:0] current_set,
  input wire logic       bridge_en,
  input wire logic       ready
);
  // ****
  // checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] prev_r;
  wire  [2:0] dph = phase_out - prev_r;
  always_ff @(posedge clk) prev_r <= phase_out;
  init_quiet_a: assert property (!ready |-> !fault_out && !step_out)
    else $error("output active before ready");
  dis_gate_a: assert property (disable_in [*8] |=> !step_out && !bridge_en)
    else $error("activity while disabled");
  short_off_a: assert property ((short_phase_in || short_ground_in) [*8]
    |=> !fault_out && led_red && !bridge_en) else $error("short not flagged");
  temp_off_a: assert property (over_temp_in [*8] |=> !fault_out && led_red)
    else $error("over temperature not flagged");
  fault_hold_a: assert property ($fell(fault_out) && !disable_in |=> !fault_out [*3])
    else $error("fault not held");
  led_red_a: assert property (led_red |-> !fault_out && !led_green)
    else $error("red led while healthy");
  step_cur_a: assert property (step_out |-> current_set == ((current_switch < 6'd9) ? 6'd9
    : (current_switch > 6'd40) ? 6'd40 : current_switch)) else $error("setpoint wrong");
  half_step_a: assert property (step_out && resolution_switch |-> dph inside {3'h1, 3'h7})
    else $error("half step phase wrong");
  full_step_a: assert property (step_out && !resolution_switch
    |-> dph inside {3'h2, 3'h6} && !phase_out[0]) else $error("full step phase wrong");
endmodule // sdc_drive_checker
bind sdc_drive sdc_drive_checker chk_inst (.clk(clk), .rst(rst), .disable_in(disable_in),
  .short_phase_in(short_phase_in), .short_ground_in(short_ground_in),
  .over_temp_in(over_temp_in), .resolution_switch(resolution_switch),
  .current_switch(current_switch), .fault_out(fault_out), .led_green(led_green),
  .led_red(led_red), .step_out(step_out), .phase_out(phase_out),
  .current_set(current_set), .bridge_en(bridge_en), .ready(ready));
`default_nettype wire

/* File: tb/sdc_drive_tb.sv */
// self-checking bench of the stepper drive control block
`timescale 1ns/1ps
`default_nettype none
module sdc_drive_tb;
  // ****
  // bench
  // ****
  logic       clk = 1'b0;
  logic       rst;
  logic       dis;
  logic [2:0] flt;
  logic       mode;
  logic       res;
  logic [5:0] cur;
  logic [1:0] idle;
  logic       last_dir = 1'b0;
  wire        pa, pb, f_out, led_g, led_r, stp, dir, br, rdy, pwa, pwb;
  wire  [2:0] ph;
  wire  [5:0] cset;
  int         fails = 0;
  int         checks_done = 0;
  int         nstep = 0;
  always #5 clk = ~clk;
  always @(posedge clk) if (stp) begin
    nstep <= nstep + 1;
    last_dir <= dir;
  end
  sdc_drive #(.IDLE_CYC(200), .INIT_CYC(20), .FLASH_CYC(16), .PWM_CYC(80)) sdc_drive_inst (
    .clk(clk), .rst(rst), .pulse_a_input(pa), .pulse_b_input(pb), .disable_in(dis),
    .short_phase_in(flt[2]), .short_ground_in(flt[1]), .over_temp_in(flt[0]),
    .pulse_mode_switch(mode), .resolution_switch(res), .current_switch(cur),
    .idle_switch(idle), .fault_out(f_out), .led_green(led_g), .led_red(led_r),
    .step_out(stp), .dir_out(dir), .phase_out(ph), .current_set(cset), .pwm_a(pwa),
    .pwm_b(pwb), .bridge_en(br), .ready(rdy));
  sdc_indexer #(.HI_CYC(8), .DWELL_CYC(10)) idx (.clk(clk), .cw_mode(mode),
    .pulse_a(pa), .pulse_b(pb));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    rst = 1'b1;
    tick(8);
    rst = 1'b0;
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_init;
    idx.step(1'b0);
    chk({rdy, f_out}, 2'h0);
    tick(12);
    chk({rdy, f_out, br, nstep[3:0]}, 7'h70);
  endtask
  task automatic t_pwm;
    int hi_a;
    int hi_b;
    hi_a = 0;
    hi_b = 0;
    cur = 6'd20;
    tick(4);
    repeat (80) begin
      tick(1);
      hi_a += pwa;
      hi_b += pwb;
    end
    chk(hi_a[15:0], 16'd40);
    chk(hi_b[15:0], 16'd0);
    cur = 6'd40;
  endtask
  task automatic t_cwccw;
    idx.step(1'b0);
    chk(last_dir, 1'b1);
    idx.step(1'b1);
    chk({last_dir, nstep[3:0]}, 5'h02);
  endtask
  task automatic t_stepdir;
    logic d0;
    mode = 1'b0;
    idx.step(1'b0);
    d0 = last_dir;
    idx.step(1'b1);
    chk({last_dir, nstep[3:0]}, {~d0, 4'h4});
  endtask
  task automatic t_res;
    logic [2:0] p0;
    p0 = ph;
    repeat (8) idx.step(1'b1);
    chk(ph, p0);
    res = 1'b0;
    repeat (4) idx.step(1'b1);
    chk({ph, nstep[4:0]}, {p0, 5'd16});
  endtask
  task automatic t_dis;
    dis = 1'b1;
    tick(10);
    idx.step(1'b1);
    chk({br, nstep[4:0]}, 6'd16);
    dis = 1'b0;
    tick(10);
  endtask
  task automatic t_fault;
    for (int i = 0; i < 3; i++) begin
      flt = 3'h1 << i;
      tick(10);
      flt = 3'h0;
      tick(10);
      idx.step(1'b1);
      chk({f_out, led_r, led_g, br, nstep[4:0]}, 9'h090);
      dis = 1'b1;
      tick(10);
      dis = 1'b0;
      tick(10);
      chk({f_out, led_r}, 2'h2);
    end
  endtask
  task automatic t_idle;
    logic [5:0] sw [3] = '{6'd5, 6'd50, 6'd23};
    logic [5:0] full [3] = '{6'd9, 6'd40, 6'd23};
    logic [5:0] low [3] = '{6'd9, 6'd20, 6'd0};
    for (int i = 0; i < 3; i++) begin
      idle = 2'(i);
      cur = sw[i];
      do_reset;
      tick(30);
      idle = 2'((i + 1) % 3); // late change must be ignored
      idx.step(1'b1);
      chk(cset, full[i]);
      tick(210);
      chk({cset, br, led_g}, {low[i], i != 2, 1'b1});
      idx.step(1'b1);
      chk(cset, full[i]);
    end
  endtask
  initial begin
    rst = 1'b1;
    dis = 1'b0;
    flt = 3'h0;
    mode = 1'b1;
    res = 1'b1;
    cur = 6'd40;
    idle = 2'h0;
    do_reset;
    t_init;
    t_pwm;
    t_cwccw;
    t_stepdir;
    t_res;
    t_dis;
    t_fault;
    t_idle;
    tally_and_finish;
  end
  initial begin
    #100_000;
    fails++;
    tally_and_finish;
  end
endmodule // sdc_drive_tb
`default_nettype wire

/* File: tb/sdc_indexer.sv */
// indexer model driving the two pulse inputs
`timescale 1ns/1ps
`default_nettype none
module sdc_indexer #(
  parameter int HI_CYC    = 15000,
  parameter int DWELL_CYC = 30000
) (
  input  wire logic clk,
  input  wire logic cw_mode,
  output var  logic pulse_a,
  output var  logic pulse_b
);
  // ****
  // pulses
  // ****
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
  end
  task automatic step(input logic ccw);
    @(posedge clk);
    #1;
    if (!cw_mode && pulse_b !== ccw) begin
      pulse_b = ccw;
      repeat (DWELL_CYC) @(posedge clk);
      #1;
    end
    if (cw_mode && ccw) pulse_b = 1'b1;
    else pulse_a = 1'b1;
    repeat (HI_CYC) @(posedge clk);
    #1;
    pulse_a = 1'b0;
    if (cw_mode) pulse_b = 1'b0;
    repeat (HI_CYC) @(posedge clk);
    #1;
  endtask
endmodule // sdc_indexer
`default_nettype wire
